// *** pic_pkg.sv ***
package pic_pkg;

    // ----------------------------------------
    // Register map (word byte addresses)
    // ----------------------------------------
    localparam logic [5:0] ADDR_FAST_CTRL = 6'h00;
    localparam logic [5:0] ADDR_REQ_LOW = 6'h04;
    localparam logic [5:0] ADDR_REQ_HIGH = 6'h08;
    localparam logic [5:0] ADDR_LEVEL_CFG0 = 6'h0c;
    localparam logic [5:0] ADDR_REQ_LEVEL = 6'h24;
    localparam logic [5:0] ADDR_SRC_NUM = 6'h28;
    localparam logic [5:0] ADDR_CUR_LEVEL = 6'h2c;
    localparam logic [2:0] NUM_LEVEL_CFG = 3'h6;

    // ----------------------------------------
    // Sizes and field positions
    // ----------------------------------------
    localparam int NUM_SRC = 24;
    localparam int LVL_W = 3;
    localparam int SRC_W = 5;
    localparam int REQ_LOW_W = 16;
    localparam int REQ_HIGH_W = 8;
    localparam int FAST_PEND_BIT = 0;
    localparam int FAST_PIN_BIT = 1;
    localparam int FAST_MASK_BIT = 2;
    localparam int SRC_PER_CFG = 4;
    localparam int CFG_FIELD_STRIDE = 4;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic FAST_MASK_RST = 1'h1;
    localparam logic [LVL_W-1:0] LEVEL_RST = 3'h0;
    localparam logic [SRC_W-1:0] SRC_RST = 5'h00;
    localparam logic [7:0] CUR_LEVEL_RST = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : pic_pkg

// *** pic_arb_if.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Arbiter request and result bundle
// ----------------------------------------
interface pic_arb_if;
    logic [pic_pkg::NUM_SRC-1:0] pending;
    logic [pic_pkg::NUM_SRC*pic_pkg::LVL_W-1:0] levels;
    logic [pic_pkg::LVL_W-1:0] cur_level;
    logic [pic_pkg::LVL_W-1:0] win_level;
    logic [pic_pkg::SRC_W-1:0] win_src;
    logic win_valid;

    modport ctrl (
        output pending,
        output levels,
        output cur_level,
        input win_level,
        input win_src,
        input win_valid
    );

    modport arb (
        input pending,
        input levels,
        input cur_level,
        output win_level,
        output win_src,
        output win_valid
    );
endinterface : pic_arb_if

`default_nettype wire

// *** pic_arbiter.sv ***
`timescale 1ns/10ps
`default_nettype none

module pic_arbiter (
    // Arbitration bundle
    pic_arb_if.arb arb_if
);

    // ----------------------------------------
    // Level then fixed priority selection
    // ----------------------------------------
    function automatic logic [pic_pkg::LVL_W+pic_pkg::SRC_W:0] pic_pick(
        input logic [pic_pkg::NUM_SRC-1:0] pend,
        input logic [pic_pkg::NUM_SRC*pic_pkg::LVL_W-1:0] lvls,
        input logic [pic_pkg::LVL_W-1:0] cur
    );
        logic [pic_pkg::LVL_W-1:0] best_lvl;
        logic [pic_pkg::SRC_W-1:0] best_src;
        logic [pic_pkg::LVL_W-1:0] lv;
        logic found;
        best_lvl = pic_pkg::LEVEL_RST;
        best_src = pic_pkg::SRC_RST;
        found = 1'b0;
        // Lower source number wins a tie: scan downward, take on >=
        for (int i = pic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            lv = lvls[i*pic_pkg::LVL_W +: pic_pkg::LVL_W];
            if (pend[i] && lv != pic_pkg::LEVEL_RST && lv >= best_lvl) begin
                best_lvl = lv;
                best_src = pic_pkg::SRC_W'(i);
                found = 1'b1;
            end
        end
        return {found && (best_lvl > cur), best_lvl, best_src};
    endfunction : pic_pick

    wire [pic_pkg::LVL_W+pic_pkg::SRC_W:0] pick_w;
    assign pick_w = pic_pick(arb_if.pending, arb_if.levels, arb_if.cur_level);
    assign arb_if.win_valid = pick_w[pic_pkg::LVL_W+pic_pkg::SRC_W];
    assign arb_if.win_level = pick_w[pic_pkg::SRC_W +: pic_pkg::LVL_W];
    assign arb_if.win_src = pick_w[pic_pkg::SRC_W-1:0];

endmodule : pic_arbiter

`default_nettype wire

// *** pic_level_enc.sv ***
`timescale 1ns/10ps
`default_nettype none

module pic_level_enc (
    // Current-level bitmap in
    input wire logic [7:0] bitmap_i,
    // Highest set bit out
    output logic [pic_pkg::LVL_W-1:0] level_o
);

    // ----------------------------------------
    // Highest set bit, zero when none
    // ----------------------------------------
    function automatic logic [pic_pkg::LVL_W-1:0] pic_top_bit(input logic [7:0] m);
        logic [pic_pkg::LVL_W-1:0] r;
        r = pic_pkg::LEVEL_RST;
        for (int i = 0; i < 8; i++) begin
            if (m[i]) begin
                r = pic_pkg::LVL_W'(i);
            end
        end
        return r;
    endfunction : pic_top_bit

    assign level_o = pic_top_bit(bitmap_i);

endmodule : pic_level_enc

`default_nettype wire

// *** pic_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none

module pic_ctrl (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Interrupt sources
    input wire logic ext_fast_input_n_i,
    input wire logic [pic_pkg::NUM_SRC-1:0] src_req_i,
    // Processor core requests
    output logic fast_request_out_n_o,
    output logic normal_request_out_n_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic fast_pending_flag_ff;
    logic fast_mask_bit_ff;
    logic fast_pin_ff;
    logic [pic_pkg::NUM_SRC-1:0] req_flags_ff;
    logic [pic_pkg::NUM_SRC*pic_pkg::LVL_W-1:0] levels_ff;
    logic [pic_pkg::LVL_W-1:0] req_level_ff;
    logic [pic_pkg::SRC_W-1:0] src_num_ff;
    logic [7:0] cur_bitmap_ff;
    logic fast_out_n_ff;
    logic norm_out_n_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [pic_pkg::LVL_W-1:0] cur_level_w;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire access_w = (avs_read_i || avs_write_i) && !ack_ff;
    wire wr_w = avs_write_i && !ack_ff;
    wire rd_w = avs_read_i && !ack_ff;
    wire sel_fast_w = avs_address_i == pic_pkg::ADDR_FAST_CTRL;
    wire sel_low_w = avs_address_i == pic_pkg::ADDR_REQ_LOW;
    wire sel_high_w = avs_address_i == pic_pkg::ADDR_REQ_HIGH;
    wire sel_rlvl_w = avs_address_i == pic_pkg::ADDR_REQ_LEVEL;
    wire sel_src_w = avs_address_i == pic_pkg::ADDR_SRC_NUM;
    wire sel_cur_w = avs_address_i == pic_pkg::ADDR_CUR_LEVEL;
    wire [5:0] cfg_off_w = avs_address_i - pic_pkg::ADDR_LEVEL_CFG0;
    wire [2:0] cfg_idx_w = cfg_off_w[4:2];
    wire sel_cfg_w = avs_address_i >= pic_pkg::ADDR_LEVEL_CFG0 && cfg_off_w[1:0] == 2'h0
        && !cfg_off_w[5] && cfg_idx_w < pic_pkg::NUM_LEVEL_CFG;
    wire src_rd_w = rd_w && sel_src_w;

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    pic_arb_if arb_bus ();

    assign arb_bus.pending = req_flags_ff;
    assign arb_bus.levels = levels_ff;
    assign arb_bus.cur_level = cur_level_w;

    pic_arbiter u_arb (
        .arb_if(arb_bus)
    );

    pic_level_enc u_enc (
        .bitmap_i(cur_bitmap_ff),
        .level_o(cur_level_w)
    );

    // ----------------------------------------
    // Fast interrupt path
    // ----------------------------------------
    wire fast_fall_w = fast_pin_ff && !ext_fast_input_n_i;
    wire fast_clr_w = wr_w && sel_fast_w && avs_writedata_i[pic_pkg::FAST_PEND_BIT];
    wire nxt_fast_pend = fast_fall_w || (fast_pending_flag_ff && !fast_clr_w);
    wire nxt_fast_out_n = !(nxt_fast_pend && !fast_mask_bit_ff);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fast_pin_ff <= 1'h1;
            fast_pending_flag_ff <= 1'h0;
            fast_mask_bit_ff <= pic_pkg::FAST_MASK_RST;
            fast_out_n_ff <= 1'h1;
        end else begin
            fast_pin_ff <= ext_fast_input_n_i;
            fast_pending_flag_ff <= nxt_fast_pend;
            if (wr_w && sel_fast_w) begin
                fast_mask_bit_ff <= avs_writedata_i[pic_pkg::FAST_MASK_BIT];
            end
            fast_out_n_ff <= nxt_fast_out_n;
        end
    end

    // ----------------------------------------
    // Normal request flags
    // ----------------------------------------
    wire [pic_pkg::NUM_SRC-1:0] clr_mask_w = {
        (wr_w && sel_high_w) ? avs_writedata_i[pic_pkg::REQ_HIGH_W-1:0] : 8'h00,
        (wr_w && sel_low_w) ? avs_writedata_i[pic_pkg::REQ_LOW_W-1:0] : 16'h0000};
    wire [pic_pkg::NUM_SRC-1:0] nxt_req_flags = src_req_i | (req_flags_ff & ~clr_mask_w);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_flags_ff <= '0;
        end else begin
            req_flags_ff <= nxt_req_flags;
        end
    end

    // ----------------------------------------
    // Level configuration, four 3-bit fields per word
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            levels_ff <= '0;
        end else if (wr_w && sel_cfg_w) begin
            for (int k = 0; k < pic_pkg::SRC_PER_CFG; k++) begin
                levels_ff[(int'(cfg_idx_w)*pic_pkg::SRC_PER_CFG+k)*pic_pkg::LVL_W +: pic_pkg::LVL_W]
                    <= avs_writedata_i[k*pic_pkg::CFG_FIELD_STRIDE +: pic_pkg::LVL_W];
            end
        end
    end

    // ----------------------------------------
    // Published winner and current-level bitmap
    // ----------------------------------------
    wire [7:0] cur_set_w = src_rd_w ? (8'h01 << req_level_ff) : 8'h00;
    wire [7:0] cur_wr_w = (wr_w && sel_cur_w) ? avs_writedata_i[7:0] : cur_bitmap_ff;
    wire [7:0] nxt_cur_bitmap = cur_wr_w | cur_set_w;
    wire nxt_norm_out_n = !arb_bus.win_valid || src_rd_w;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_level_ff <= pic_pkg::LEVEL_RST;
            src_num_ff <= pic_pkg::SRC_RST;
            cur_bitmap_ff <= pic_pkg::CUR_LEVEL_RST;
            norm_out_n_ff <= 1'h1;
        end else begin
            if (src_rd_w || !arb_bus.win_valid) begin
                req_level_ff <= pic_pkg::LEVEL_RST;
                src_num_ff <= pic_pkg::SRC_RST;
            end else begin
                req_level_ff <= arb_bus.win_level;
                src_num_ff <= arb_bus.win_src;
            end
            cur_bitmap_ff <= nxt_cur_bitmap;
            norm_out_n_ff <= nxt_norm_out_n;
        end
    end

    // ----------------------------------------
    // Level field of one source, zero past the last
    // ----------------------------------------
    function automatic logic [pic_pkg::LVL_W-1:0] pic_lvl_of(
        input logic [pic_pkg::NUM_SRC*pic_pkg::LVL_W-1:0] lvls,
        input int idx
    );
        return (idx < pic_pkg::NUM_SRC) ? lvls[idx*pic_pkg::LVL_W +: pic_pkg::LVL_W]
            : pic_pkg::LEVEL_RST;
    endfunction : pic_lvl_of

    // ----------------------------------------
    // Read data and one-wait-state handshake
    // ----------------------------------------
    wire [31:0] cfg_rd_w = {16'h0000,
        1'b0, pic_lvl_of(levels_ff, int'(cfg_idx_w)*4+3),
        1'b0, pic_lvl_of(levels_ff, int'(cfg_idx_w)*4+2),
        1'b0, pic_lvl_of(levels_ff, int'(cfg_idx_w)*4+1),
        1'b0, pic_lvl_of(levels_ff, int'(cfg_idx_w)*4)};
    wire [31:0] fast_rd_w = {29'h0000_0000, fast_mask_bit_ff, fast_pin_ff, fast_pending_flag_ff};
    wire [31:0] nxt_rdata = sel_fast_w ? fast_rd_w :
        sel_low_w ? {16'h0000, req_flags_ff[15:0]} :
        sel_high_w ? {24'h00_0000, req_flags_ff[23:16]} :
        sel_cfg_w ? cfg_rd_w :
        sel_rlvl_w ? {29'h0000_0000, req_level_ff} :
        sel_src_w ? {27'h000_0000, src_num_ff} :
        sel_cur_w ? {24'h00_0000, cur_bitmap_ff} : pic_pkg::READ_ZERO;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_ff <= 1'h0;
            rdata_ff <= pic_pkg::READ_ZERO;
        end else begin
            ack_ff <= access_w;
            if (rd_w) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;
    assign avs_readdata_o = rdata_ff;
    assign fast_request_out_n_o = fast_out_n_ff;
    assign normal_request_out_n_o = norm_out_n_ff;

    // ----------------------------------------
    // Fast path checks
    // ----------------------------------------
    fast_set_edge_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $past(fast_pin_ff) && !fast_pin_ff |-> fast_pending_flag_ff)
        else $error("Fast edge did not set pending flag");

    fast_out_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fast_pending_flag_ff && !fast_mask_bit_ff && !fast_clr_w |=> !fast_request_out_n_o)
        else $error("Fast request not asserted");

    fast_masked_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !fast_request_out_n_o |-> $past(fast_mask_bit_ff) == 1'b0)
        else $error("Fast request driven while masked");

    fast_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fast_clr_w && !fast_fall_w |=> !fast_pending_flag_ff)
        else $error("Fast flag not cleared");

    fast_clr_out_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fast_clr_w && !fast_fall_w |=> fast_request_out_n_o)
        else $error("Fast request not dropped");

    fast_in_service_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fast_pending_flag_ff && !fast_mask_bit_ff && !fast_clr_w && cur_bitmap_ff != 8'h00
        |=> !fast_request_out_n_o)
        else $error("Fast request gated by service level");

    fast_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !fast_fall_w && !fast_clr_w |=> fast_pending_flag_ff == $past(fast_pending_flag_ff))
        else $error("Fast flag changed without cause");

    fast_mask_wr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_w && sel_fast_w
        |=> fast_mask_bit_ff == $past(avs_writedata_i[pic_pkg::FAST_MASK_BIT]))
        else $error("Fast mask not written");

    // ----------------------------------------
    // Normal path checks
    // ----------------------------------------
    flag_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        |clr_mask_w && !(|src_req_i) |=> (req_flags_ff & $past(clr_mask_w)) == '0)
        else $error("Request flag not cleared");

    flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        |src_req_i |=> (req_flags_ff & $past(src_req_i)) == $past(src_req_i))
        else $error("Request flag not set");

    flag_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clr_mask_w == '0 && src_req_i == '0 |=> $stable(req_flags_ff))
        else $error("Request flags changed without cause");

    norm_out_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !normal_request_out_n_o |-> $past(req_flags_ff) != '0)
        else $error("Normal request without pending flag");

    norm_raise_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        arb_bus.win_valid && !src_rd_w |=> !normal_request_out_n_o)
        else $error("Normal request not raised");

    norm_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !arb_bus.win_valid |=> normal_request_out_n_o)
        else $error("Normal request without winner");

    src_read_cur_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        src_rd_w && !(wr_w && sel_cur_w) |=> cur_bitmap_ff[$past(req_level_ff)]
        ##0 normal_request_out_n_o)
        else $error("Source read did not set current bit");

    src_read_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        src_rd_w |=> req_level_ff == pic_pkg::LEVEL_RST)
        else $error("Source read did not zero level");

    src_num_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        src_rd_w |=> src_num_ff == pic_pkg::SRC_RST)
        else $error("Source read did not zero number");

    win_level_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        arb_bus.win_valid && !src_rd_w |=> req_level_ff == $past(arb_bus.win_level)
        && req_level_ff > $past(cur_level_w))
        else $error("Request level not published");

    cur_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_w && sel_cur_w |=> cur_bitmap_ff == $past(avs_writedata_i[7:0]))
        else $error("Current-level bitmap not written");

    cur_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !src_rd_w && !(wr_w && sel_cur_w) |=> $stable(cur_bitmap_ff))
        else $error("Current-level bitmap changed without cause");

    cfg_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !(wr_w && sel_cfg_w) |=> $stable(levels_ff))
        else $error("Level fields changed without write");

    cfg_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_w && sel_cfg_w |=> pic_lvl_of(levels_ff, int'($past(cfg_idx_w))*4)
        == $past(avs_writedata_i[pic_pkg::LVL_W-1:0]))
        else $error("Level field not written");

    // ----------------------------------------
    // Arbiter and level checks
    // ----------------------------------------
    win_mask_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        arb_bus.win_valid |-> arb_bus.win_level != pic_pkg::LEVEL_RST)
        else $error("Masked source won arbitration");

    win_above_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        arb_bus.win_valid |-> arb_bus.win_level > cur_level_w)
        else $error("Winner not above current level");

    win_source_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        arb_bus.win_valid |-> arb_bus.pending[arb_bus.win_src]
        && pic_lvl_of(levels_ff, int'(arb_bus.win_src)) == arb_bus.win_level)
        else $error("Winner level and source disagree");

    level_enc_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cur_bitmap_ff >> cur_level_w) == {7'h00, |cur_bitmap_ff}
        && (|cur_bitmap_ff || cur_level_w == pic_pkg::LEVEL_RST))
        else $error("Current level not highest bitmap bit");

endmodule : pic_ctrl

`default_nettype wire

// *** pic_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Processor core with its disable bits
// ----------------------------------------
module pic_core_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Requests from the controller
    input wire logic fast_request_out_n_i,
    input wire logic normal_request_out_n_i,
    // Accepted exception counts
    output logic [7:0] fast_cnt_o,
    output logic [7:0] norm_cnt_o
);
    logic fast_dis_ff;
    logic norm_dis_ff;
    logic [2:0] hold_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fast_dis_ff <= 1'b0;
            norm_dis_ff <= 1'b0;
            hold_ff <= 3'h0;
            fast_cnt_o <= 8'h00;
            norm_cnt_o <= 8'h00;
        end else if (!fast_request_out_n_i && !fast_dis_ff) begin
            fast_dis_ff <= 1'b1;
            norm_dis_ff <= 1'b1;
            fast_cnt_o <= fast_cnt_o + 8'h01;
        end else if (!normal_request_out_n_i && !norm_dis_ff) begin
            norm_dis_ff <= 1'b1;
            hold_ff <= 3'h4;
            norm_cnt_o <= norm_cnt_o + 8'h01;
        end else begin
            if (fast_request_out_n_i) begin
                fast_dis_ff <= 1'b0;
            end
            if (hold_ff != 3'h0) begin
                hold_ff <= hold_ff - 3'h1;
            end else begin
                norm_dis_ff <= 1'b0;
            end
        end
    end
endmodule : pic_core_model

`default_nettype wire

// *** prioritized_irq_fiq_controller_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module prioritized_irq_fiq_controller_tb;
    logic clk_sys_i;
    logic rst_n_i;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_n;
    logic [23:0] src;
    logic fast_n;
    logic norm_n;
    logic [7:0] fast_cnt;
    logic [7:0] norm_cnt;
    int failures;
    int n_compared;
    int cycles;
    int i;
    logic [2:0] lvl;
    logic [5:0] a;

    pic_ctrl pic_ctrl_i (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
        .ext_fast_input_n_i(ext_n), .src_req_i(src),
        .fast_request_out_n_o(fast_n), .normal_request_out_n_o(norm_n)
    );

    pic_core_model pic_core_model_i (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .fast_request_out_n_i(fast_n),
        .normal_request_out_n_i(norm_n), .fast_cnt_o(fast_cnt), .norm_cnt_o(norm_cnt)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    task automatic end_sim;
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus_wait;
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest !== 1'b0);
    endtask : bus_wait

    task automatic wr_reg(input logic [5:0] ad, input logic [31:0] d);
        @(posedge clk_sys_i);
        avs_address <= ad;
        avs_writedata <= d;
        avs_write <= 1'b1;
        bus_wait();
        avs_write <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [5:0] ad, input logic [31:0] exp);
        @(posedge clk_sys_i);
        avs_address <= ad;
        avs_read <= 1'b1;
        bus_wait();
        chk(avs_readdata, exp);
        avs_read <= 1'b0;
    endtask : rd_chk

    task automatic out_chk(input logic f, input logic n);
        @(negedge clk_sys_i);
        chk({30'h0, fast_n, norm_n}, {30'h0, f, n});
    endtask : out_chk

    task automatic pulse_src(input logic [23:0] v);
        @(posedge clk_sys_i);
        src <= v;
        @(posedge clk_sys_i);
        src <= 24'h000000;
        repeat (2) @(posedge clk_sys_i);
    endtask : pulse_src

    initial begin
        failures = 0;
        n_compared = 0;
        cycles = 0;
        rst_n_i = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        ext_n = 1'b1;
        src = 24'h000000;
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // ----------------------------------------
        // Reset state
        // ----------------------------------------
        out_chk(1'b1, 1'b1);
        rd_chk(pic_pkg::ADDR_FAST_CTRL, 32'h0000_0006);
        rd_chk(pic_pkg::ADDR_REQ_LEVEL, 32'h0000_0000);
        rd_chk(pic_pkg::ADDR_CUR_LEVEL, 32'h0000_0000);
        rd_chk(6'h30, 32'h0000_0000);
        // ----------------------------------------
        // Fast request path
        // ----------------------------------------
        @(posedge clk_sys_i);
        ext_n <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        ext_n <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rd_chk(pic_pkg::ADDR_FAST_CTRL, 32'h0000_0007);
        out_chk(1'b1, 1'b1);
        wr_reg(pic_pkg::ADDR_CUR_LEVEL, 32'h0000_0080);
        wr_reg(pic_pkg::ADDR_FAST_CTRL, 32'h0000_0000);
        out_chk(1'b0, 1'b1);
        rd_chk(pic_pkg::ADDR_FAST_CTRL, 32'h0000_0003);
        chk({24'h0, fast_cnt}, 32'h0000_0001);
        wr_reg(pic_pkg::ADDR_FAST_CTRL, 32'h0000_0001);
        out_chk(1'b1, 1'b1);
        rd_chk(pic_pkg::ADDR_FAST_CTRL, 32'h0000_0002);
        wr_reg(pic_pkg::ADDR_CUR_LEVEL, 32'h0000_0000);
        // ----------------------------------------
        // Nested levels 2 then 7
        // ----------------------------------------
        wr_reg(6'h10, 32'h0000_0020);
        pulse_src(24'h000020);
        out_chk(1'b1, 1'b0);
        rd_chk(pic_pkg::ADDR_REQ_LOW, 32'h0000_0020);
        rd_chk(pic_pkg::ADDR_REQ_LEVEL, 32'h0000_0002);
        rd_chk(pic_pkg::ADDR_SRC_NUM, 32'h0000_0005);
        out_chk(1'b1, 1'b1);
        rd_chk(pic_pkg::ADDR_REQ_LEVEL, 32'h0000_0000);
        rd_chk(pic_pkg::ADDR_CUR_LEVEL, 32'h0000_0004);
        wr_reg(6'h14, 32'h0000_0070);
        pulse_src(24'h000200);
        out_chk(1'b1, 1'b0);
        rd_chk(pic_pkg::ADDR_REQ_LEVEL, 32'h0000_0007);
        rd_chk(pic_pkg::ADDR_SRC_NUM, 32'h0000_0009);
        rd_chk(pic_pkg::ADDR_CUR_LEVEL, 32'h0000_0084);
        wr_reg(pic_pkg::ADDR_REQ_LOW, 32'h0000_0200);
        rd_chk(pic_pkg::ADDR_REQ_LOW, 32'h0000_0020);
        wr_reg(pic_pkg::ADDR_CUR_LEVEL, 32'h0000_0004);
        out_chk(1'b1, 1'b1);
        wr_reg(pic_pkg::ADDR_CUR_LEVEL, 32'h0000_0000);
        out_chk(1'b1, 1'b0);
        rd_chk(pic_pkg::ADDR_SRC_NUM, 32'h0000_0005);
        wr_reg(pic_pkg::ADDR_REQ_LOW, 32'h0000_0020);
        wr_reg(pic_pkg::ADDR_CUR_LEVEL, 32'h0000_0000);
        wr_reg(6'h10, 32'h0000_0000);
        wr_reg(6'h14, 32'h0000_0000);
        // ----------------------------------------
        // Tie-break and level zero masking
        // ----------------------------------------
        wr_reg(6'h0c, 32'h0000_4000);
        wr_reg(6'h18, 32'h0000_0004);
        pulse_src(24'h101008);
        rd_chk(pic_pkg::ADDR_REQ_HIGH, 32'h0000_0010);
        rd_chk(pic_pkg::ADDR_REQ_LEVEL, 32'h0000_0004);
        rd_chk(pic_pkg::ADDR_SRC_NUM, 32'h0000_0003);
        wr_reg(pic_pkg::ADDR_REQ_LOW, 32'h0000_0008);
        wr_reg(pic_pkg::ADDR_CUR_LEVEL, 32'h0000_0000);
        rd_chk(pic_pkg::ADDR_SRC_NUM, 32'h0000_000c);
        wr_reg(pic_pkg::ADDR_REQ_LOW, 32'h0000_1000);
        wr_reg(pic_pkg::ADDR_CUR_LEVEL, 32'h0000_0000);
        out_chk(1'b1, 1'b1);
        rd_chk(pic_pkg::ADDR_REQ_LEVEL, 32'h0000_0000);
        wr_reg(pic_pkg::ADDR_REQ_HIGH, 32'h0000_0010);
        rd_chk(pic_pkg::ADDR_REQ_HIGH, 32'h0000_0000);
        wr_reg(6'h0c, 32'h0000_0000);
        wr_reg(6'h18, 32'h0000_0000);
        // ----------------------------------------
        // Every source, number and field position
        // ----------------------------------------
        for (i = 0; i < 24; i++) begin
            lvl = 3'(1 + i % 7);
            a = 6'(12 + 4 * (i / 4));
            wr_reg(a, 32'(lvl) << (4 * (i % 4)));
            pulse_src(24'h000001 << i);
            out_chk(1'b1, 1'b0);
            rd_chk(pic_pkg::ADDR_REQ_LEVEL, 32'(lvl));
            rd_chk(pic_pkg::ADDR_SRC_NUM, 32'(i));
            rd_chk(pic_pkg::ADDR_CUR_LEVEL, 32'h0000_0001 << lvl);
            if (i < 16) begin
                wr_reg(pic_pkg::ADDR_REQ_LOW, 32'h0000_0001 << i);
            end else begin
                wr_reg(pic_pkg::ADDR_REQ_HIGH, 32'h0000_0001 << (i - 16));
            end
            wr_reg(pic_pkg::ADDR_CUR_LEVEL, 32'h0000_0000);
            wr_reg(a, 32'h0000_0000);
            out_chk(1'b1, 1'b1);
        end
        chk({31'h0, norm_cnt != 8'h00}, 32'h0000_0001);
        end_sim();
    end
endmodule : prioritized_irq_fiq_controller_tb

`default_nettype wire
